// ---- rtl/wre_regs.sv ----
`timescale 1ns/1ps
module wre_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wre_pkg::wre_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wre_pkg::wre_event_t events,
  input wre_pkg::wre_masks_t masks,
  input wire logic sync_clock_valid,
  input wire logic analog_supply_undervoltage,
  input wire logic [1:0] reset_counter_threshold,
  input wire logic watchdog_reset_pulse,
  input wire logic watchdog_reset_active,
  input wire logic restart_done,
  input wire logic [2:0] converter_enable_req,
  output logic [2:0] converter_enable,
  output logic watchdog_lock,
  output logic trigger_input_pulldown,
  output logic watchdog_reset_output,
  output logic watchdog_reset_output_oe_n,
  output logic system_restart_req,
  output logic fuse_reload_req,
  output logic startup_rerun,
  output logic thermal_warning_status_clear,
  output logic irq_n_out,
  output logic irq_n_oe_n
);

  // ==========================================================
  // helpers
  // set wins over a clear in the same cycle
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = set | (cur & ~clr);
  endfunction

  function automatic logic [2:0] thr_target(input logic [1:0] sel);
    case (sel)
      2'h1: thr_target = wre_pkg::THR_TARGET_1;
      2'h2: thr_target = wre_pkg::THR_TARGET_2;
      2'h3: thr_target = wre_pkg::THR_TARGET_4;
      default: thr_target = 3'h0;
    endcase
  endfunction

  // ==========================================================
  // decode
  logic wr_cfg, wr_status, wr_swrst, wr_top, wr_rre, wr_buck, wr_boost, wr_mon;
  assign wr_cfg = reg_req.wr && reg_req.addr == wre_pkg::OFS_WD_CONFIG_B;
  assign wr_status = reg_req.wr && reg_req.addr == wre_pkg::OFS_WATCHDOG_STATUS;
  assign wr_swrst = reg_req.wr && reg_req.addr == wre_pkg::OFS_SOFTWARE_RESET_BIT;
  assign wr_top = reg_req.wr && reg_req.addr == wre_pkg::OFS_TOP_EVENT;
  assign wr_rre = reg_req.wr && reg_req.addr == wre_pkg::OFS_REG_RESET_EVENT;
  assign wr_buck = reg_req.wr && reg_req.addr == wre_pkg::OFS_BUCK_EVENT;
  assign wr_boost = reg_req.wr && reg_req.addr == wre_pkg::OFS_BOOST_EVENT;
  assign wr_mon = reg_req.wr && reg_req.addr == wre_pkg::OFS_MONITOR_EVENT;

  // ==========================================================
  // software reset
  logic software_reset_bit_pending;
  logic soft_reset;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      software_reset_bit_pending <= 1'b0;
    end else if (software_reset_bit_pending) begin
      software_reset_bit_pending <= 1'b0;
    end else begin
      software_reset_bit_pending <= wr_swrst && reg_req.wdata[wre_pkg::SOFTWARE_RESET_BIT_POS];
    end
  end

  // either cause takes the whole bank but rre_ev back to defaults
  assign soft_reset = software_reset_bit_pending || analog_supply_undervoltage;

  // ==========================================================
  // watchdog_config_b
  logic [7:0] cfg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= wre_pkg::RST_WD_CONFIG_B;
    end else if (soft_reset) begin
      cfg <= wre_pkg::RST_WD_CONFIG_B;
    end else if (wr_cfg && !cfg[wre_pkg::CFG_LOCK]) begin
      // lock can only be raised; once up nothing here moves
      cfg <= {reg_req.wdata[7], 2'h0, reg_req.wdata[4:0]};
    end
  end

  assign watchdog_lock = cfg[wre_pkg::CFG_LOCK];
  assign trigger_input_pulldown = cfg[wre_pkg::CFG_PULLDOWN];

  // ==========================================================
  // watchdog reset output pin
  logic wdr_level;
  assign wdr_level = watchdog_reset_active ^ cfg[wre_pkg::CFG_POLARITY];

  always_comb begin
    if (cfg[wre_pkg::CFG_OUT_TYPE]) begin
      // open-drain: only pull low, let the pull-up make the high level
      watchdog_reset_output = 1'b0;
      watchdog_reset_output_oe_n = wdr_level;
    end else begin
      watchdog_reset_output = wdr_level;
      watchdog_reset_output_oe_n = 1'b0;
    end
  end

  // ==========================================================
  // watchdog status: reset counter and restart flag, outside the lock
  logic [2:0] reset_count;
  logic restart_flag;
  logic flag_clear_busy;
  logic cnt_clear_busy;
  logic restart_blocked;
  logic [2:0] next_count;
  logic restart_fire;

  assign restart_blocked = restart_flag && cfg[wre_pkg::CFG_BLOCK_MODE];

  always_comb begin
    next_count = reset_count;
    restart_fire = 1'b0;
    if (wr_status && reg_req.wdata[wre_pkg::ST_CNT_CLEAR]) begin
      next_count = 3'h0;
    end
    if (watchdog_reset_pulse && reset_counter_threshold != wre_pkg::THR_DISABLED) begin
      next_count = next_count + 3'h1;
      if (next_count >= thr_target(reset_counter_threshold)) begin
        next_count = 3'h0;
        restart_fire = !restart_blocked;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reset_count <= 3'h0;
    end else if (soft_reset) begin
      reset_count <= 3'h0;
    end else begin
      reset_count <= next_count;
    end
  end

  // clear bits read one for the cycle after the write, then zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_clear_busy <= 1'b0;
      cnt_clear_busy <= 1'b0;
    end else if (soft_reset) begin
      flag_clear_busy <= 1'b0;
      cnt_clear_busy <= 1'b0;
    end else begin
      flag_clear_busy <= wr_status && reg_req.wdata[wre_pkg::ST_FLAG_CLEAR];
      cnt_clear_busy <= wr_status && reg_req.wdata[wre_pkg::ST_CNT_CLEAR];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      restart_flag <= 1'b0;
    end else if (soft_reset) begin
      restart_flag <= 1'b0;
    end else if (restart_done) begin
      restart_flag <= 1'b1;
    end else if (flag_clear_busy) begin
      restart_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      system_restart_req <= 1'b0;
      fuse_reload_req <= 1'b0;
      startup_rerun <= 1'b0;
    end else begin
      system_restart_req <= restart_fire;
      fuse_reload_req <= (restart_fire && cfg[wre_pkg::CFG_FUSE_RELOAD]) || soft_reset;
      startup_rerun <= soft_reset;
    end
  end

  // ==========================================================
  // event registers
  logic [7:0] top_ev, rre_ev, buck_ev, boost_ev, mon_ev;
  logic sync_valid_q;
  logic [7:0] top_set, buck_set, boost_set, mon_set;
  logic [7:0] top_clr, rre_clr, buck_clr, boost_clr, mon_clr;
  logic [7:0] top_read;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_valid_q <= 1'b0;
    end else begin
      sync_valid_q <= sync_clock_valid;
    end
  end

  always_comb begin
    top_set = 8'h00;
    top_set[wre_pkg::TOP_LOAD_MEAS] = events.load_measure_ready_event;
    top_set[wre_pkg::TOP_SYNC_CLK] = sync_clock_valid ^ sync_valid_q;
    top_set[wre_pkg::TOP_THERM_SD] = events.thermal_shutdown_event;
    top_set[wre_pkg::TOP_THERM_WARN] = events.thermal_warning_event;
    top_set[wre_pkg::TOP_OVP] = events.input_overvoltage_event;
    buck_set = {1'b0, events.buck_b_power_good_event, events.buck_b_short_event,
                events.buck_b_current_limit_event, 1'b0, events.buck_a_power_good_event,
                events.buck_a_short_event, events.buck_a_current_limit_event};
    boost_set = {5'h00, events.boost_power_good_event, events.boost_short_event,
                 events.boost_current_limit_event};
    mon_set = {3'h0, events.monitor_b_power_good_event, 1'b0,
               events.monitor_a_power_good_event, 1'b0,
               events.analog_power_good_event};
  end

  assign top_clr = wr_top ? reg_req.wdata & wre_pkg::TOP_LATCH_MASK : 8'h00;
  assign rre_clr = wr_rre ? reg_req.wdata & wre_pkg::REG_RESET_MASK : 8'h00;
  assign buck_clr = wr_buck ? reg_req.wdata & wre_pkg::BUCK_MASK_BITS : 8'h00;
  assign boost_clr = wr_boost ? reg_req.wdata & wre_pkg::BOOST_MASK_BITS : 8'h00;
  assign mon_clr = wr_mon ? reg_req.wdata & wre_pkg::MONITOR_MASK_BITS : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      top_ev <= wre_pkg::RST_ZERO;
      buck_ev <= wre_pkg::RST_ZERO;
      boost_ev <= wre_pkg::RST_ZERO;
      mon_ev <= wre_pkg::RST_ZERO;
    end else if (soft_reset) begin
      top_ev <= wre_pkg::RST_ZERO;
      buck_ev <= wre_pkg::RST_ZERO;
      boost_ev <= wre_pkg::RST_ZERO;
      mon_ev <= wre_pkg::RST_ZERO;
    end else begin
      top_ev <= w1c(top_ev, top_set, top_clr);
      buck_ev <= w1c(buck_ev, buck_set, buck_clr);
      boost_ev <= w1c(boost_ev, boost_set, boost_clr);
      mon_ev <= w1c(mon_ev, mon_set, mon_clr);
    end
  end

  // survives its own cause: it is the record that the bank was reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rre_ev <= wre_pkg::RST_ZERO;
    end else begin
      rre_ev <= w1c(rre_ev, {7'h00, soft_reset}, rre_clr);
    end
  end

  // summaries are not stored, so they drop the cycle the source empties
  always_comb begin
    top_read = top_ev;
    top_read[wre_pkg::TOP_MONITOR_SUM] = |mon_ev;
    top_read[wre_pkg::TOP_BOOST_SUM] = |boost_ev;
    top_read[wre_pkg::TOP_BUCK_SUM] = |buck_ev;
  end

  // ==========================================================
  // converter gating and thermal side effects
  logic tsd_active;
  assign tsd_active = top_ev[wre_pkg::TOP_THERM_SD];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      converter_enable <= 3'h0;
      thermal_warning_status_clear <= 1'b0;
    end else begin
      // held off during a bank reset so startup begins from off
      converter_enable <= (tsd_active || soft_reset) ? 3'h0 : converter_enable_req;
      thermal_warning_status_clear <= tsd_active
                                      && top_clr[wre_pkg::TOP_THERM_SD]
                                      && !top_set[wre_pkg::TOP_THERM_SD];
    end
  end

  // ==========================================================
  // interrupt pin, open-drain active low
  logic irq;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(top_ev & wre_pkg::TOP_LATCH_MASK & ~masks.top)
             | |(rre_ev & ~masks.reg_reset)
             | |(buck_ev & ~masks.buck)
             | |(boost_ev & ~masks.boost)
             | |(mon_ev & ~masks.monitor);
    end
  end

  assign irq_n_out = 1'b0;
  assign irq_n_oe_n = !irq;

  // ==========================================================
  // read port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        wre_pkg::OFS_WD_CONFIG_B: reg_rdata <= cfg;
        wre_pkg::OFS_WATCHDOG_STATUS: reg_rdata <= {3'h0, flag_clear_busy, restart_flag,
                                              cnt_clear_busy, reset_count[1:0]};
        wre_pkg::OFS_SOFTWARE_RESET_BIT: reg_rdata <= {7'h00, software_reset_bit_pending};
        wre_pkg::OFS_TOP_EVENT: reg_rdata <= top_read;
        wre_pkg::OFS_REG_RESET_EVENT: reg_rdata <= rre_ev;
        wre_pkg::OFS_BUCK_EVENT: reg_rdata <= buck_ev;
        wre_pkg::OFS_BOOST_EVENT: reg_rdata <= boost_ev;
        wre_pkg::OFS_MONITOR_EVENT: reg_rdata <= mon_ev;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ---- rtl/wre_pkg.sv ----
package wre_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_WD_CONFIG_B = 8'h1D;
  localparam logic [7:0] OFS_WATCHDOG_STATUS = 8'h1E;
  localparam logic [7:0] OFS_SOFTWARE_RESET_BIT = 8'h1F;
  localparam logic [7:0] OFS_TOP_EVENT = 8'h20;
  localparam logic [7:0] OFS_REG_RESET_EVENT = 8'h21;
  localparam logic [7:0] OFS_BUCK_EVENT = 8'h22;
  localparam logic [7:0] OFS_BOOST_EVENT = 8'h23;
  localparam logic [7:0] OFS_MONITOR_EVENT = 8'h24;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_WD_CONFIG_B = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ==========================================================
  // field positions, watchdog_config_b
  localparam int CFG_LOCK = 7;
  localparam int CFG_BLOCK_MODE = 4;
  localparam int CFG_FUSE_RELOAD = 3;
  localparam int CFG_PULLDOWN = 2;
  localparam int CFG_POLARITY = 1;
  localparam int CFG_OUT_TYPE = 0;

  // watchdog_status
  localparam int ST_FLAG_CLEAR = 4;
  localparam int ST_FLAG = 3;
  localparam int ST_CNT_CLEAR = 2;

  // software_reset_cmd
  localparam int SOFTWARE_RESET_BIT_POS = 0;

  // top_event_flags
  localparam int TOP_LOAD_MEAS = 7;
  localparam int TOP_MONITOR_SUM = 6;
  localparam int TOP_BOOST_SUM = 5;
  localparam int TOP_BUCK_SUM = 4;
  localparam int TOP_SYNC_CLK = 3;
  localparam int TOP_THERM_SD = 2;
  localparam int TOP_THERM_WARN = 1;
  localparam int TOP_OVP = 0;

  // bits that physically exist in each event register
  localparam logic [7:0] TOP_LATCH_MASK = 8'h8F;
  localparam logic [7:0] REG_RESET_MASK = 8'h01;
  localparam logic [7:0] BUCK_MASK_BITS = 8'h77;
  localparam logic [7:0] BOOST_MASK_BITS = 8'h07;
  localparam logic [7:0] MONITOR_MASK_BITS = 8'h15;

  // reset counter threshold encodings
  localparam logic [1:0] THR_DISABLED = 2'h0;
  localparam logic [2:0] THR_TARGET_1 = 3'h1;
  localparam logic [2:0] THR_TARGET_2 = 3'h2;
  localparam logic [2:0] THR_TARGET_4 = 3'h4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wre_reg_req_t;

  // one-cycle pulses from the analog and measurement blocks
  typedef struct packed {
    logic load_measure_ready_event;
    logic thermal_shutdown_event;
    logic thermal_warning_event;
    logic input_overvoltage_event;
    logic buck_a_short_event;
    logic buck_b_short_event;
    logic boost_short_event;
    logic buck_a_power_good_event;
    logic buck_b_power_good_event;
    logic boost_power_good_event;
    logic buck_a_current_limit_event;
    logic buck_b_current_limit_event;
    logic boost_current_limit_event;
    logic analog_power_good_event;
    logic monitor_a_power_good_event;
    logic monitor_b_power_good_event;
  } wre_event_t;

  typedef struct packed {
    logic [7:0] top;
    logic [7:0] reg_reset;
    logic [7:0] buck;
    logic [7:0] boost;
    logic [7:0] monitor;
  } wre_masks_t;

endpackage

// ---- dv/wre_regs_chk.sv ----
`timescale 1ns/1ps
module wre_regs_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wre_pkg::wre_reg_req_t reg_req,
  input wre_pkg::wre_event_t events,
  input wre_pkg::wre_masks_t masks,
  input wire logic [1:0] reset_counter_threshold,
  input wire logic watchdog_reset_pulse,
  input wire logic watchdog_reset_active,
  input wire logic [2:0] converter_enable_req,
  input wire logic [2:0] converter_enable,
  input wire logic watchdog_lock,
  input wire logic watchdog_reset_output,
  input wire logic watchdog_reset_output_oe_n,
  input wire logic system_restart_req,
  input wire logic fuse_reload_req,
  input wire logic startup_rerun,
  input wire logic irq_n_oe_n
);
  // ==========================================================
  // shadow of config bits 4:0; stale for the one cycle of startup_rerun, so that cycle is skipped
  logic [4:0] cfg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= 5'h01;
    end else if (startup_rerun) begin
      cfg <= 5'h01;
    end else if (reg_req.wr && reg_req.addr == wre_pkg::OFS_WD_CONFIG_B && !watchdog_lock) begin
      cfg <= reg_req.wdata[4:0];
    end
  end

  // ==========================================================
  // properties
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_lock_set;
    reg_req.wr && reg_req.addr == wre_pkg::OFS_WD_CONFIG_B && reg_req.wdata[7] |=> watchdog_lock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock bit not set");

  property p_lock_hold;
    $fell(watchdog_lock) |-> startup_rerun;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock bit dropped");

  property p_push_pull;
    !startup_rerun && !cfg[0] |->
      watchdog_reset_output == (watchdog_reset_active ^ cfg[1]) && !watchdog_reset_output_oe_n;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull level wrong");

  property p_open_drain;
    !startup_rerun && cfg[0] |->
      !watchdog_reset_output && watchdog_reset_output_oe_n == (watchdog_reset_active ^ cfg[1]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

  property p_restart;
    watchdog_reset_pulse && reset_counter_threshold == 2'h1 && !cfg[4] |=> system_restart_req;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not requested");

  property p_fuse_reload;
    system_restart_req && !startup_rerun && !$past(startup_rerun) |->
      fuse_reload_req == $past(cfg[3]);
  endproperty
  a_fuse_reload: assert property (p_fuse_reload) else $error("fuse reload wrong");

  property p_no_restart;
    reset_counter_threshold == 2'h0 && $past(reset_counter_threshold) == 2'h0
      |-> !system_restart_req;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart while disabled");

  property p_conv_gate;
    (converter_enable & ~$past(converter_enable_req)) == 3'h0;
  endproperty
  a_conv_gate: assert property (p_conv_gate) else $error("enable without request");

  property p_thermal_off;
    events.thermal_shutdown_event |-> ##2 converter_enable == 3'h0;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("converters not off");

  property p_irq;
    events.input_overvoltage_event && !masks.top[0] |-> ##2 !irq_n_oe_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

bind wre_regs wre_regs_chk wre_regs_chk_i (.clk_sys, .reset_n, .reg_req, .events, .masks,
  .reset_counter_threshold, .watchdog_reset_pulse, .watchdog_reset_active,
  .converter_enable_req, .converter_enable, .watchdog_lock, .watchdog_reset_output,
  .watchdog_reset_output_oe_n, .system_restart_req, .fuse_reload_req, .startup_rerun,
  .irq_n_oe_n);

// ---- dv/wre_host_model.sv ----
`timescale 1ns/1ps
module wre_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output wre_pkg::wre_reg_req_t reg_req
);
  initial reg_req = '0;

  // one-cycle strobe launched just after an edge, data taken after the answering edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys) #1;
    reg_req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) #1;
    reg_req = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys) #1;
    reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) #1;
    reg_req = '0;
    v = reg_rdata;
  endtask
endmodule

// ---- dv/wre_regs_tb_top.sv ----
`timescale 1ns/1ps
module wre_regs_tb_top;
  logic clk_sys, reset_n, sync_clock_valid, analog_supply_undervoltage, watchdog_reset_pulse;
  logic watchdog_reset_active, restart_done, watchdog_lock, trigger_input_pulldown;
  logic watchdog_reset_output, watchdog_reset_output_oe_n, system_restart_req, irq_n_oe_n;
  logic fuse_reload_req, thermal_warning_status_clear, irq_n_out;
  logic [1:0] reset_counter_threshold;
  logic [2:0] converter_enable_req, converter_enable;
  logic [7:0] reg_rdata, a, b;
  wre_pkg::wre_reg_req_t reg_req;
  wre_pkg::wre_event_t events;
  wre_pkg::wre_masks_t masks;
  int fail_count, compares;
  logic [7:0] ev_addr [16] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h22, 8'h22, 8'h23, 8'h22,
    8'h22, 8'h23, 8'h22, 8'h22, 8'h23, 8'h24, 8'h24, 8'h24};
  logic [7:0] ev_bit [16] = '{8'h80, 8'h04, 8'h02, 8'h01, 8'h02, 8'h20, 8'h02, 8'h04,
    8'h40, 8'h04, 8'h01, 8'h10, 8'h01, 8'h01, 8'h04, 8'h10};

  wre_regs wre_regs_i (.clk_sys, .reset_n, .reg_req, .reg_rdata, .events, .masks,
    .sync_clock_valid, .analog_supply_undervoltage, .reset_counter_threshold,
    .watchdog_reset_pulse, .watchdog_reset_active, .restart_done, .converter_enable_req,
    .converter_enable, .watchdog_lock, .trigger_input_pulldown, .watchdog_reset_output,
    .watchdog_reset_output_oe_n, .system_restart_req, .fuse_reload_req, .startup_rerun(),
    .thermal_warning_status_clear, .irq_n_out, .irq_n_oe_n);
  wre_host_model host_i (.clk_sys, .reg_rdata, .reg_req);

  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask

  task automatic evp(input logic [15:0] v);
    events = wre_pkg::wre_event_t'(v);
    step(1);
    events = '0;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic [7:0] v;
    host_i.rd(ad, v);
    chk(v & m, e);
  endtask

  task automatic wdp(input logic e);
    pulse(watchdog_reset_pulse);
    chk(8'(system_restart_req), 8'(e));
    // every restart scenario runs with the fuse reload enable set
    chk(8'(fuse_reload_req), 8'(e));
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    {reset_n, sync_clock_valid, analog_supply_undervoltage, watchdog_reset_pulse} = '0;
    {watchdog_reset_active, restart_done, reset_counter_threshold, converter_enable_req} = '0;
    events = '0;
    masks = '0;
    step(2);
    reset_n = 1;
    for (int i = 'h1D; i <= 'h24; i++) rchk(8'(i), (i == 'h1D) ? 8'h01 : 8'h00);
    rchk(8'h30, 8'h00);
    chk({7'h00, irq_n_out}, 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      a = ev_addr[k];
      b = ev_bit[k];
      evp(16'h8000 >> k);
      step(1);
      chk(8'(irq_n_oe_n), 8'h00);
      rchk(a, b);
      rchk(8'h20, (a == 8'h20) ? b : 8'h10 << (a - 8'h22));
      host_i.wr(a, 8'h00);
      rchk(a, b);
      host_i.wr(a, b);
      rchk(a, 8'h00);
      rchk(8'h20, 8'h00);
      chk(8'(irq_n_oe_n), 8'h01);
    end
    masks.top = 8'hFF;
    evp(16'h1000);
    step(2);
    chk(8'(irq_n_oe_n), 8'h01);
    host_i.wr(8'h20, 8'h01);
    masks = '0;
    sync_clock_valid = 1;
    step(2);
    rchk(8'h20, 8'h08);
    host_i.wr(8'h20, 8'h08);
    sync_clock_valid = 0;
    step(2);
    rchk(8'h20, 8'h08);
    host_i.wr(8'h20, 8'h08);
    $display("test event flags done");
    host_i.wr(8'h1D, 8'h1E);
    rchk(8'h1D, 8'h1E);
    chk(8'(trigger_input_pulldown), 8'h01);
    watchdog_reset_active = 1;
    #1;
    chk({7'h00, watchdog_reset_output, watchdog_reset_output_oe_n}, 8'h00);
    host_i.wr(8'h1D, 8'h1C);
    chk({7'h00, watchdog_reset_output, watchdog_reset_output_oe_n}, 8'h02);
    host_i.wr(8'h1D, 8'h0D);
    chk({7'h00, watchdog_reset_output, watchdog_reset_output_oe_n}, 8'h01);
    watchdog_reset_active = 0;
    $display("test output config done");
    reset_counter_threshold = 2'h1;
    wdp(1'b1);
    host_i.wr(8'h1D, 8'h1D);
    pulse(restart_done);
    rchk(8'h1E, 8'h08, 8'hFC);
    wdp(1'b0);
    host_i.wr(8'h1E, 8'h10);
    rchk(8'h1E, 8'h00, 8'hFC);
    wdp(1'b1);
    reset_counter_threshold = 2'h0;
    step(1);
    wdp(1'b0);
    reset_counter_threshold = 2'h3;
    host_i.wr(8'h1E, 8'h04);
    wdp(1'b0);
    wdp(1'b0);
    rchk(8'h1E, 8'h02, 8'h07);
    host_i.wr(8'h1E, 8'h04);
    rchk(8'h1E, 8'h00, 8'h07);
    $display("test restart counter done");
    host_i.wr(8'h1D, 8'h9C);
    chk(8'(watchdog_lock), 8'h01);
    host_i.wr(8'h1D, 8'h01);
    rchk(8'h1D, 8'h9C);
    pulse(restart_done);
    rchk(8'h1E, 8'h08, 8'hF8);
    host_i.wr(8'h1E, 8'h10);
    rchk(8'h1E, 8'h00, 8'hF8);
    converter_enable_req = 3'h7;
    step(2);
    chk(8'(converter_enable), 8'h07);
    evp(16'h4000);
    step(2);
    chk(8'(converter_enable), 8'h00);
    host_i.wr(8'h20, 8'h04);
    chk(8'(thermal_warning_status_clear), 8'h01);
    step(2);
    chk(8'(converter_enable), 8'h07);
    $display("test lock and thermal done");
    host_i.wr(8'h1F, 8'h01);
    step(3);
    rchk(8'h1F, 8'h00);
    rchk(8'h1D, 8'h01);
    rchk(8'h21, 8'h01);
    host_i.wr(8'h21, 8'h01);
    pulse(analog_supply_undervoltage);
    step(3);
    rchk(8'h21, 8'h01);
    $display("test soft reset done");
    summarize;
  end

  initial begin
    #40000;
    fail_count++;
    summarize;
  end
endmodule
